// ===== design/osc_cal_pkg.sv
// osc_cal_pkg: register map, field layout, reset values and calibration constants
// assumes: APB slave with 32-bit data, one aligned word per register
package osc_cal_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_XT_CAL = 12'h000;
    localparam logic [11:0] ADDR_RC_CAL = 12'h004;
    localparam logic [11:0] ADDR_OSC_CTRL = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_CORR_CNT = 12'h010;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int XT_OFF_LSB = 0;
    localparam int XT_COARSE_BIT = 7;
    localparam int RC_OFF_LSB = 0;
    localparam int RC_RANGE_LSB = 14;
    localparam int OSC_SEL_BIT = 0;
    localparam int EXT_SLOW_LSB = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [6:0] XT_OFF_RST = 7'h00;
    localparam logic [13:0] RC_OFF_RST = 14'h0000;
    localparam logic [1:0] FIELD2_RST = 2'h0;
    localparam logic OSC_SEL_RST = 1'b0;

    // ------------------------------------------------------------
    // calibration timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int XT_PERIOD_S = 32;
    localparam int XT_TICK_HZ = 16384;
    localparam int RC_PERIOD_S = 8192;
    localparam int RC_TICK_HZ = 64;
    // both paths see 2^19 corrected-stage ticks per full period
    localparam logic [20:0] CAL_TICKS = 21'(XT_PERIOD_S * XT_TICK_HZ);
    localparam logic [20:0] RC_CAL_TICKS = 21'(RC_PERIOD_S * RC_TICK_HZ);
    // 122 ppm is 64 steps of 1.907 ppm over the 32 s period
    localparam int EXT_SLOW_STEPS = 64;

    // ------------------------------------------------------------
    // configuration carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] xt_cal_offset;
        logic xt_cal_coarse_sel;
        logic [1:0] xt_ext_slow;
        logic [13:0] rc_cal_offset;
        logic [1:0] rc_cal_range;
        logic osc_select;
    } cal_cfg_t;

endpackage : osc_cal_pkg

// ===== design/osc_digital_calibration.sv
// osc_digital_calibration: distributed pulse add/remove on the divided oscillator clock
// assumes: XT_OSC and RC_OSC arrive asynchronously; CLOCK is far faster than both
//
// Functional notes
// RULE1: crystal selected: corrections act on the 16.384 kHz divider stage.
// RULE2: normal crystal mode: offset pulses corrected per 32 second period.
// RULE3: coarse crystal mode: offset pulses corrected per 16 second period.
// RULE4: crystal offset is signed two's complement, -64 to +63.
// RULE5: extended slowdown removes 122 ppm per unit, period unchanged.
// RULE6: crystal corrections spread evenly, jitter at most one 16.384 kHz period.
// RULE7: calibrated tick feeds counters, timers, watchdog and clock output.
// RULE8: software zeroes crystal fields before measuring raw frequency.
// RULE9: software derives crystal settings from measured step count range.
// RULE10: software selects oscillator via osc_select before measuring it.
// RULE11: RC selected: corrections act on the 64 Hz stage with 128 Hz pulses.
// RULE12: RC range 00: corrections per 8,192 seconds, 1.907 ppm steps.
// RULE13: RC range 01: corrections per 4,096 seconds, 3.82 ppm steps.
// RULE14: RC range 10: corrections per 2,048 seconds, 7.64 ppm steps.
// RULE15: RC range 11: corrections per 1,024 seconds, 15.28 ppm steps.
// RULE16: RC offset is signed two's complement, -8,192 to +8,191.
// RULE17: RC corrections spread evenly, jitter at most one 64 Hz period.
// RULE18: software derives RC range and scaled offset from step count.
// RULE19: negative offset removes pulses, positive adds, zero does nothing.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module osc_digital_calibration
    import osc_cal_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // oscillator inputs (asynchronous)
    input wire logic XT_OSC,
    input wire logic RC_OSC,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // calibrated clock towards counters, timers and clock pin
    output logic CAL_TICK,
    output logic CAL_CLK,
    output logic ACTIVE_OSC
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // even spread: add magnitude each tick, fire when a full period is passed
    function automatic logic [20:0] spread_step(input logic [19:0] acc, input logic [16:0] mag);
        logic [20:0] sum;
        sum = {1'b0, acc} + {4'h0, mag};
        if (sum >= CAL_TICKS) begin
            spread_step = {1'b1, 20'(sum - CAL_TICKS)};
        end else begin
            spread_step = {1'b0, sum[19:0]};
        end
    endfunction : spread_step

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == ADDR_XT_CAL) || (a == ADDR_RC_CAL) || (a == ADDR_OSC_CTRL) ||
                    (a == ADDR_STATUS) || (a == ADDR_CORR_CNT);
    endfunction : is_mapped

    // ------------------------------------------------------------
    // oscillator synchronisers
    // ------------------------------------------------------------
    logic [1:0] osc_in;
    logic [1:0] f1_r;
    logic [1:0] f2_r;
    logic [1:0] f3_r;
    logic [1:0] lvl_r;
    logic [1:0] lvl_nxt;
    logic [1:0] rise;

    assign osc_in = {RC_OSC, XT_OSC};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            // three-stage capture, first stage read only by second
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    f1_r[gi] <= 1'b0;
                    f2_r[gi] <= 1'b0;
                    f3_r[gi] <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                end else begin
                    f1_r[gi] <= osc_in[gi];
                    f2_r[gi] <= f1_r[gi];
                    f3_r[gi] <= f2_r[gi];
                    lvl_r[gi] <= lvl_nxt[gi];
                end
            end
            // level accepted once stages two and three agree
            always_comb begin
                lvl_nxt[gi] = (f2_r[gi] == f3_r[gi]) ? f3_r[gi] : lvl_r[gi];
                rise[gi] = lvl_nxt[gi] && !lvl_r[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    cal_cfg_t cfg_r;
    cal_cfg_t cfg_nxt;
    logic [15:0] corr_cnt_r;
    logic [15:0] corr_cnt_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic wr_en;
    logic access;
    logic fire;
    logic [19:0] acc_r; // spread accumulator, also read back in status

    assign access = PSEL && PENABLE;
    assign wr_en = access && PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = access && !is_mapped(PADDR);
    assign PRDATA = prdata_r;

    // write decode and read data captured in the setup cycle
    always_comb begin
        cfg_nxt = cfg_r;
        corr_cnt_nxt = corr_cnt_r;
        prdata_nxt = prdata_r;
        if (wr_en && PADDR == ADDR_XT_CAL) begin
            cfg_nxt.xt_cal_offset = PWDATA[XT_OFF_LSB +: 7];
            cfg_nxt.xt_cal_coarse_sel = PWDATA[XT_COARSE_BIT];
        end
        if (wr_en && PADDR == ADDR_RC_CAL) begin
            cfg_nxt.rc_cal_offset = PWDATA[RC_OFF_LSB +: 14];
            cfg_nxt.rc_cal_range = PWDATA[RC_RANGE_LSB +: 2];
        end
        if (wr_en && PADDR == ADDR_OSC_CTRL) begin
            cfg_nxt.osc_select = PWDATA[OSC_SEL_BIT];
            cfg_nxt.xt_ext_slow = PWDATA[EXT_SLOW_LSB +: 2];
        end
        // clear by write, a correction in the same cycle still counts
        if (wr_en && PADDR == ADDR_CORR_CNT) begin
            corr_cnt_nxt = 16'h0000;
        end
        if (fire) begin
            corr_cnt_nxt = corr_cnt_nxt + 16'h0001;
        end
        if (PSEL && !PENABLE) begin
            prdata_nxt = 32'h0000_0000;
            unique case (PADDR)
                ADDR_XT_CAL: prdata_nxt = {24'h0, cfg_r.xt_cal_coarse_sel, cfg_r.xt_cal_offset};
                ADDR_RC_CAL: prdata_nxt = {16'h0, cfg_r.rc_cal_range, cfg_r.rc_cal_offset};
                ADDR_OSC_CTRL: prdata_nxt = {26'h0, cfg_r.xt_ext_slow, 3'h0, cfg_r.osc_select};
                ADDR_STATUS: prdata_nxt = {11'h0, acc_r[19:0], ACTIVE_OSC};
                ADDR_CORR_CNT: prdata_nxt = {16'h0, corr_cnt_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // register update
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_r <= '{XT_OFF_RST, 1'b0, FIELD2_RST, RC_OFF_RST, FIELD2_RST, OSC_SEL_RST};
            corr_cnt_r <= 16'h0000;
            prdata_r <= 32'h0000_0000;
        end else begin
            cfg_r <= cfg_nxt;
            corr_cnt_r <= corr_cnt_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // effective correction per full period
    // ------------------------------------------------------------
    logic signed [17:0] xt_eff;
    logic signed [17:0] rc_eff;
    logic signed [17:0] eff;
    logic [17:0] mag_full;
    logic [16:0] mag;
    logic neg;

    // offsets in 32 s units; coarse doubles, slowdown subtracts 64 per unit
    always_comb begin
        xt_eff = 18'({{11{cfg_r.xt_cal_offset[6]}}, cfg_r.xt_cal_offset}); // [RULE4]
        if (cfg_r.xt_cal_coarse_sel) begin
            xt_eff = 18'(xt_eff <<< 1); // [RULE3]
        end
        xt_eff = 18'(xt_eff - 18'(EXT_SLOW_STEPS * int'(cfg_r.xt_ext_slow))); // [RULE5]
        // rc offset scaled by range within one 8,192 s span
        rc_eff = 18'({{4{cfg_r.rc_cal_offset[13]}}, cfg_r.rc_cal_offset}); // [RULE16]
        rc_eff = 18'(rc_eff <<< cfg_r.rc_cal_range); // [RULE12] [RULE13] [RULE14] [RULE15]
        eff = cfg_r.osc_select ? rc_eff : xt_eff; // [RULE11]
        neg = eff[17]; // [RULE19]
        mag_full = neg ? 18'(-eff) : 18'(eff);
        mag = mag_full[16:0];
    end

    // ------------------------------------------------------------
    // divider stage with distributed correction
    // ------------------------------------------------------------
    logic src_edge;
    logic phase_r;
    logic phase_nxt;
    logic [19:0] acc_nxt;
    logic add_pend_r;
    logic add_pend_nxt;
    logic tick_r;
    logic tick_nxt;
    logic clk_r;
    logic clk_nxt;
    logic sel_r;
    logic [20:0] step;

    assign src_edge = cfg_r.osc_select ? rise[1] : rise[0]; // [RULE1] [RULE11]
    assign step = spread_step(acc_r, mag);
    assign fire = src_edge && phase_r && step[20] && (mag != 17'h0)
                  && (cfg_r.osc_select == sel_r); // [RULE19]
    assign CAL_TICK = tick_r;
    assign CAL_CLK = clk_r;
    assign ACTIVE_OSC = sel_r;

    // divide by two; gate the tick or add one on the opposite half
    always_comb begin
        phase_nxt = phase_r;
        acc_nxt = acc_r;
        add_pend_nxt = add_pend_r;
        tick_nxt = 1'b0;
        clk_nxt = clk_r;
        if (cfg_r.osc_select != sel_r) begin
            // oscillator switch restarts the correction span
            phase_nxt = 1'b0;
            acc_nxt = 20'h00000;
            add_pend_nxt = 1'b0;
        end else if (src_edge) begin
            phase_nxt = !phase_r;
            if (phase_r) begin
                acc_nxt = step[19:0]; // [RULE6] [RULE17]
                tick_nxt = !(fire && neg); // [RULE2] [RULE19]
                add_pend_nxt = fire && !neg;
            end else begin
                tick_nxt = add_pend_r; // [RULE11] [RULE2]
                add_pend_nxt = 1'b0;
            end
        end
        if (tick_nxt) begin
            clk_nxt = !clk_r; // [RULE7]
        end
    end

    // divider state registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            phase_r <= 1'b0;
            acc_r <= 20'h00000;
            add_pend_r <= 1'b0;
            tick_r <= 1'b0;
            clk_r <= 1'b0;
            sel_r <= OSC_SEL_RST;
        end else begin
            phase_r <= phase_nxt;
            acc_r <= acc_nxt;
            add_pend_r <= add_pend_nxt;
            tick_r <= tick_nxt;
            clk_r <= clk_nxt;
            sel_r <= cfg_r.osc_select;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_tick_from_edge;
        @(posedge CLOCK) disable iff (RST) CAL_TICK |-> $past(src_edge);
    endproperty
    a_tick_from_edge: assert property (p_tick_from_edge) else $error("stray tick"); // [RULE1]

    property p_neg_gates;
        @(posedge CLOCK) disable iff (RST) (fire && neg) |=> !CAL_TICK ##1 !CAL_TICK;
    endproperty
    a_neg_gates: assert property (p_neg_gates) else $error("removal not gated"); // [RULE19]

    property p_pos_adds;
        @(posedge CLOCK) disable iff (RST)
            (src_edge && !phase_r && add_pend_r && cfg_r.osc_select == sel_r) |=> CAL_TICK;
    endproperty
    a_pos_adds: assert property (p_pos_adds) else $error("inserted tick missing"); // [RULE19]

    property p_pos_add_now;
        @(posedge CLOCK) disable iff (RST) (fire && !neg) |=> CAL_TICK && add_pend_r;
    endproperty
    a_pos_add_now: assert property (p_pos_add_now) else $error("add lost"); // [RULE2]

    property p_zero_none;
        @(posedge CLOCK) disable iff (RST) (eff == 18'sh0) |-> !fire;
    endproperty
    a_zero_none: assert property (p_zero_none) else $error("zero offset fired"); // [RULE19]

    property p_acc_bound;
        @(posedge CLOCK) disable iff (RST) {1'b0, acc_r} < CAL_TICKS;
    endproperty
    a_acc_bound: assert property (p_acc_bound) else $error("accumulator overrun"); // [RULE6]

    property p_switch_restart;
        @(posedge CLOCK) disable iff (RST) (cfg_r.osc_select != sel_r) |=> acc_r == 20'h00000;
    endproperty
    a_switch_restart: assert property (p_switch_restart) else $error("span kept"); // [RULE11]

    property p_xt_min;
        @(posedge CLOCK) disable iff (RST)
            (!cfg_r.osc_select && cfg_r.xt_cal_offset == 7'h40 && cfg_r.xt_cal_coarse_sel
             && cfg_r.xt_ext_slow == 2'h3) |-> (neg && mag == 17'd320);
    endproperty
    a_xt_min: assert property (p_xt_min) else $error("crystal range end wrong"); // [RULE5]

    property p_rc_max;
        @(posedge CLOCK) disable iff (RST)
            (cfg_r.osc_select && cfg_r.rc_cal_offset == 14'h2000 && cfg_r.rc_cal_range == 2'h3)
            |-> (neg && mag == 17'd65536);
    endproperty
    a_rc_max: assert property (p_rc_max) else $error("rc range end wrong"); // [RULE15]

    property p_normal_tick;
        @(posedge CLOCK) disable iff (RST)
            (src_edge && phase_r && !fire && cfg_r.osc_select == sel_r) |=> CAL_TICK;
    endproperty
    a_normal_tick: assert property (p_normal_tick) else $error("plain tick missing"); // [RULE7]

    c_gate: cover property (@(posedge CLOCK) disable iff (RST) fire && neg);
    c_add: cover property (@(posedge CLOCK) disable iff (RST) fire && !neg);
    c_switch: cover property (@(posedge CLOCK) disable iff (RST) $rose(sel_r));

endmodule : osc_digital_calibration

// ===== tb/osc_digital_calibration_tb_top.sv
// osc_digital_calibration_tb_top: apb register checks and tick-spreading checks
// assumes: osc_cal_pkg and the design compiled first; bench drives every port itself
`timescale 1ns/1ps
module osc_digital_calibration_tb_top
    import osc_cal_pkg::*;
;
    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic XT_OSC = 1'b0;
    logic RC_OSC = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic CAL_TICK;
    logic CAL_CLK;
    logic ACTIVE_OSC;
    logic use_rc = 1'b0;
    logic [1:0] xt_div = 2'h0;
    logic [2:0] rc_div = 3'h0;
    logic [31:0] rdata;
    logic err;
    int fails = 0;
    int check_count = 0;
    int osc_rises = 0;
    int ticks;
    int togs;
    int max_gap;
    int corr;

    osc_digital_calibration DUT (
        .CLOCK(CLOCK), .RST(RST), .XT_OSC(XT_OSC), .RC_OSC(RC_OSC),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CAL_TICK(CAL_TICK), .CAL_CLK(CAL_CLK), .ACTIVE_OSC(ACTIVE_OSC)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 CLOCK = ~CLOCK;
    end

    // ------------------------------------------------------------
    // oscillators: crystal period 8 clocks, rc period 10 clocks
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        xt_div <= xt_div + 2'h1;
        if (xt_div == 2'h3) begin
            XT_OSC <= ~XT_OSC;
            if (!use_rc && !XT_OSC) osc_rises <= osc_rises + 1;
        end
        rc_div <= (rc_div == 3'h4) ? 3'h0 : rc_div + 3'h1;
        if (rc_div == 3'h4) begin
            RC_OSC <= ~RC_OSC;
            if (use_rc && !RC_OSC) osc_rises <= osc_rises + 1;
        end
    end

    // ------------------------------------------------------------
    // comparison, apb and window tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task in_range(input int v, input int lo, input int hi);
        check({31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask : in_range

    // one apb transfer: setup, then access until pready at an edge
    task apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= wdata;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rdata = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb_xfer

    task wr(input logic [11:0] addr, input logic [31:0] data);
        apb_xfer(1'b1, addr, data);
    endtask : wr

    task rd_chk(input logic [11:0] addr, input logic [31:0] mask, input logic [31:0] exp);
        apb_xfer(1'b0, addr, 32'h0);
        check(rdata & mask, exp);
    endtask : rd_chk

    // counts ticks, clock toggles and widest tick gap over a number of osc rises
    task run_window(input int edges);
        int start;
        int gap;
        logic last_clk;
        start = osc_rises;
        gap = 0;
        ticks = 0;
        togs = 0;
        max_gap = 0;
        last_clk = CAL_CLK;
        while (osc_rises - start < edges) begin
            @(posedge CLOCK);
            if (CAL_TICK === 1'b1) begin
                ticks++;
                if (ticks > 1 && gap > max_gap) max_gap = gap;
                gap = 0;
            end else begin
                gap++;
            end
            if (CAL_CLK !== last_clk) togs++;
            last_clk = CAL_CLK;
        end
    endtask : run_window

    task close_out();
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // watchdog against a hang
    initial begin
        #1800000;
        fails++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge CLOCK);
        RST <= 1'b0;
        // reset values and field widths
        rd_chk(ADDR_XT_CAL, 32'hffffffff, 32'h0);
        rd_chk(ADDR_RC_CAL, 32'hffffffff, 32'h0);
        rd_chk(ADDR_OSC_CTRL, 32'hffffffff, 32'h0);
        rd_chk(ADDR_CORR_CNT, 32'hffffffff, 32'h0);
        wr(ADDR_XT_CAL, 32'hffffffff);
        rd_chk(ADDR_XT_CAL, 32'hffffffff, 32'h000000ff);
        wr(ADDR_RC_CAL, 32'hffffffff);
        rd_chk(ADDR_RC_CAL, 32'hffffffff, 32'h0000ffff);
        wr(ADDR_OSC_CTRL, 32'hffffffff);
        rd_chk(ADDR_OSC_CTRL, 32'hffffffff, 32'h00000031);
        wr(ADDR_XT_CAL, 32'h0);
        wr(ADDR_RC_CAL, 32'h0);
        wr(ADDR_OSC_CTRL, 32'h0);
        // read-only status and unmapped place
        wr(ADDR_STATUS, 32'hffffffff);
        rd_chk(ADDR_STATUS, 32'h1, 32'h0);
        apb_xfer(1'b0, 12'h014, 32'h0);
        check(rdata, 32'h0);
        check({31'h0, err}, 32'h1);
        // crystal, zero offset: one tick per two osc rises, no corrections
        wr(ADDR_CORR_CNT, 32'h0);
        run_window(200);
        in_range(ticks, 99, 101);
        check(32'(togs), 32'(ticks));
        rd_chk(ADDR_CORR_CNT, 32'h0000ffff, 32'h0);
        // crystal, coarse offset -64 plus slowdown 3: one removal per 1639 ticks
        wr(ADDR_OSC_CTRL, 32'h30);
        wr(ADDR_XT_CAL, 32'hc0);
        wr(ADDR_CORR_CNT, 32'h0);
        run_window(3600);
        in_range(ticks, 1797, 1801);
        rd_chk(ADDR_CORR_CNT, 32'h0000ffff, 32'h1);
        // switch to rc path
        wr(ADDR_XT_CAL, 32'h0);
        wr(ADDR_OSC_CTRL, 32'h1);
        use_rc <= 1'b1;
        rd_chk(ADDR_STATUS, 32'h1, 32'h1);
        check({31'h0, ACTIVE_OSC}, 32'h1);
        // rc offset -8192 in every range: 4, 8, 16, 32 removals per 256 ticks
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_RC_CAL, 32'h2000 | (r << 14));
            wr(ADDR_CORR_CNT, 32'h0);
            run_window(512);
            apb_xfer(1'b0, ADDR_CORR_CNT, 32'h0);
            corr = int'(rdata[15:0]);
            in_range(corr, (4 << r) - 1, (4 << r) + 1);
            in_range(ticks + corr, 255, 257);
            in_range(max_gap, 37, 41);
        end
        // rc offset +8191 in the widest range: inserted ticks
        wr(ADDR_RC_CAL, 32'hdfff);
        wr(ADDR_CORR_CNT, 32'h0);
        run_window(320);
        apb_xfer(1'b0, ADDR_CORR_CNT, 32'h0);
        corr = int'(rdata[15:0]);
        in_range(corr, 18, 21);
        in_range(ticks - corr, 158, 162);
        in_range(max_gap, 17, 21);
        check(32'(togs), 32'(ticks));
        close_out();
    end

endmodule : osc_digital_calibration_tb_top
